// ---- tkq_consts.svh ----
/*
  Constants of the touch-key query command decoder: command codes,
  field positions, response lengths, CRC and timing figures.
  Assumes it is included by bare name from the package and the core.
*/
// Notes on behaviour
// - First-key bit 7: two or more touches.
// - First-key bit 6: calibration, cal failure, sync, comms or self-test fault.
// - Low five bits: first key, 0x1F none.
// - One data byte then CRC of command+data.
// - All-keys: three detect bytes then CRC.
// - Error flags: three bytes then CRC.
// - Self-test command returns line fault bitfield.
// - Dump halts scanning, sends 100+CRC, resumes.
// - Checksum command returns stored setups CRC.
// - Echo returns inverted last command, clears error.
// - Diagnostic: five bytes, no CRC.
// - Signal and reference go low byte first.
// - Key status: enabled, detect, calibrating bits.
// - Key status: low reference, five cal failures.
// - Key calibration only in its scan slot.
// - Scheduled calibration answers inverted command.
// - Unknown command sets communications error.
`ifndef TKQ_CONSTS_SVH
`define TKQ_CONSTS_SVH
`define TKQ_NKEYS 24
`define TKQ_KEY_MAX 5'h17
`define TKQ_CMD_NULL 8'h00
`define TKQ_CMD_SETUPS 8'h01
`define TKQ_CMD_CALALL 8'h03
`define TKQ_CMD_RESET 8'h04
`define TKQ_CMD_GSTAT 8'h05
`define TKQ_CMD_FIRST 8'h06
`define TKQ_CMD_ALL 8'h07
`define TKQ_CMD_ERR 8'h0B
`define TKQ_CMD_SELF 8'h0C
`define TKQ_CMD_DUMP 8'h0D
`define TKQ_CMD_NVCRC 8'h0E
`define TKQ_CMD_ECHO 8'h0F
`define TKQ_GRP_DIAG 2'h1
`define TKQ_GRP_KSTAT 2'h2
`define TKQ_GRP_KCAL 2'h3
`define TKQ_FK_MULTI 7
`define TKQ_FK_FLAG 6
`define TKQ_NO_TOUCH 5'h1F
`define TKQ_LEN_ONE 7'h01
`define TKQ_LEN_THREE 7'h03
`define TKQ_LEN_DIAG 7'h05
`define TKQ_LEN_DUMP 7'h64
`define TKQ_CRC_POLY 8'h31
`define TKQ_CRC_INIT 8'h00
`define TKQ_BIT_LAST 4'h7
`define TKQ_CLK_HZ 10000000
`define TKQ_CAL_WIN_MS 100
`define TKQ_TMR_W 20
`endif

// ---- tkq_pkg.sv ----
/*
  Types of the touch-key query command decoder.
  Assumes the constants header is on the include path.
*/
`default_nettype none
`include "tkq_consts.svh"
package tkq_pkg;
  // Response engine modes.
  typedef enum logic {TKQ_IDLE, TKQ_EMIT} tkq_mode_t;
  // Per-key state vectors from the sensing logic.
  typedef struct packed {
    logic [`TKQ_NKEYS-1:0] detect;
    logic [`TKQ_NKEYS-1:0] enabled;
    logic [`TKQ_NKEYS-1:0] cal;
    logic [`TKQ_NKEYS-1:0] calfail;
    logic [`TKQ_NKEYS-1:0] lowref;
    logic [`TKQ_NKEYS-1:0] err;
  } tkq_keys_t;
  // Diagnostic values of the selected key.
  typedef struct packed {
    logic [15:0] signal;
    logic [15:0] refv;
    logic [7:0] normal_integrator_count;
  } tkq_diag_t;
  // Whole register state of the core.
  typedef struct packed {
    logic [2:0] sclk;
    logic [1:0] ss;
    logic [1:0] mosi;
    logic [3:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic miso;
    logic [7:0] last_cmd;
    logic [7:0] cal_prev;
    logic [`TKQ_TMR_W-1:0] tmr;
    logic comm_err;
    logic cal_pend;
    logic cal_stb;
    logic [4:0] cal_key;
    tkq_mode_t mode;
    logic [7:0] cmd;
    logic [7:0] ans;
    logic [6:0] idx;
    logic [6:0] len;
    logic [7:0] crc;
    logic use_crc;
    logic halt;
  } tkq_state_t;
endpackage
`default_nettype wire

// ---- tkq_fifo.sv ----
/*
  Response byte FIFO with valid and ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tkq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointers and fill count as one state word.
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } tkq_fifo_st_t;
  tkq_fifo_st_t q, d; // State and its next value.
  logic [W-1:0] mem [DEPTH]; // Byte storage.
  logic wen; // Write this cycle.
  logic ren; // Read this cycle.

  // Full and empty come straight from the count.
  assign o_in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data = mem[q.rd];
  assign wen = i_in_valid && o_in_ready;
  assign ren = o_out_valid && i_out_ready;

  // Pointer and count update.
  always_comb begin
    d = q;
    if (wen) begin
      d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
    end
    if (ren) begin
      d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(wen) - (AW+1)'(ren);
  end

  // State register.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage write; contents need no reset.
  always_ff @(posedge i_mclk) begin
    if (wen) begin
      mem[q.wr] <= i_in_data;
    end
  end
endmodule // tkq_fifo
`default_nettype wire

// ---- tkq_core.sv ----
/*
  Serial query command decoder of the touch-key controller: takes
  command bytes from the serial port, builds the answers (CRC-8 except echo, checksum, diagnostic, calibration ack),
  schedules single-key calibrations and reports a line fault status.
  Assumes sensing logic on i_mclk supplies key state, diagnostics and
  the setups store; serial pins are asynchronous to i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tkq_consts.svh"
module tkq_core
  import tkq_pkg::*;
#(
  parameter int CAL_WIN_CYC = `TKQ_CAL_WIN_MS * (`TKQ_CLK_HZ / 1000),
  parameter int FIFO_DEPTH = 8
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_sclk,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  output logic o_miso,
  input wire tkq_keys_t i_keys,
  input wire logic i_sync_fail,
  input wire logic i_selftest_fail,
  input wire logic [7:0] i_line_fault_selftest,
  input wire logic [7:0] i_nv_crc,
  input wire logic [7:0] i_setup_data,
  output logic [6:0] o_setup_addr,
  input wire tkq_diag_t i_diag,
  output logic [4:0] o_diag_key,
  input wire logic [4:0] i_slot_key,
  output logic o_cal_stb,
  output logic [4:0] o_cal_key,
  output logic o_scan_halt,
  output logic o_comm_err
);
  // Calibration pair window in clock cycles.
  localparam logic [`TKQ_TMR_W-1:0] WIN = `TKQ_TMR_W'(CAL_WIN_CYC);

  tkq_state_t q, d; // State and its next value.
  logic rise; // Link clock rising edge.
  logic fall; // Link clock falling edge.
  logic active; // Select is asserted.
  logic rx_done; // A whole byte arrived this cycle.
  logic [7:0] rx_byte; // The byte that arrived.
  logic push; // Engine offers a byte.
  logic in_rdy; // FIFO can take it.
  logic [7:0] in_data; // Offered byte.
  logic out_vld; // FIFO holds a byte.
  logic pop; // Byte taken for sending.
  logic [7:0] out_data; // Head of the FIFO.
  logic [7:0] rsp; // Data byte at the current index.
  logic [4:0] first; // Lowest touched key.
  logic multi; // Two or more touches.
  logic flag6; // Summary fault flag.
  logic last; // Engine sends its final byte.
  logic [4:0] kk; // Key selected by the command.

  // ****************************************
  // CRC-8 of one byte
  // ****************************************
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `TKQ_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // ****************************************
  // Answer buffer
  // ****************************************
  tkq_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_in_valid(push),
    .o_in_ready(in_rdy),
    .i_in_data(in_data),
    .o_out_valid(out_vld),
    .i_out_ready(pop),
    .o_out_data(out_data)
  );

  // ****************************************
  // Key summaries
  // ****************************************

  // Lowest touched key and touch count flags.
  always_comb begin
    first = `TKQ_NO_TOUCH;
    for (int i = `TKQ_NKEYS - 1; i >= 0; i--) begin
      if (i_keys.detect[i]) begin
        first = 5'(i);
      end
    end
    multi = |(i_keys.detect & (i_keys.detect - 1'b1));
    flag6 = |i_keys.cal || |i_keys.calfail || i_sync_fail ||
            q.comm_err || i_selftest_fail;
  end

  // ****************************************
  // Answer byte selection
  // ****************************************

  // Data byte chosen by command and index.
  always_comb begin
    kk = q.cmd[4:0];
    rsp = `TKQ_CMD_NULL;
    unique case (q.cmd)
      `TKQ_CMD_FIRST: rsp = {multi, flag6, 1'b0, first};
      `TKQ_CMD_ALL: rsp = i_keys.detect[{q.idx[1:0], 3'b000} +: 8];
      `TKQ_CMD_ERR: rsp = i_keys.err[{q.idx[1:0], 3'b000} +: 8];
      `TKQ_CMD_SELF: rsp = i_line_fault_selftest;
      `TKQ_CMD_DUMP: rsp = i_setup_data;
      `TKQ_CMD_NVCRC: rsp = i_nv_crc;
      `TKQ_CMD_ECHO: rsp = q.ans;
      default: begin
        if (q.cmd[7:6] == `TKQ_GRP_DIAG) begin
          // Signal and reference go low byte first.
          unique case (q.idx[2:0])
            3'h0: rsp = i_diag.signal[7:0];
            3'h1: rsp = i_diag.signal[15:8];
            3'h2: rsp = i_diag.refv[7:0];
            3'h3: rsp = i_diag.refv[15:8];
            default: rsp = i_diag.normal_integrator_count;
          endcase
        end else if (q.cmd[7:6] == `TKQ_GRP_KSTAT) begin
          rsp = {3'h0, i_keys.enabled[kk], i_keys.detect[kk],
                 i_keys.lowref[kk], i_keys.cal[kk],
                 i_keys.calfail[kk]};
        end else begin
          rsp = q.ans;
        end
      end
    endcase
  end

  // ****************************************
  // Link, decoder and engine
  // ****************************************

  // Next state of the whole core.
  always_comb begin
    d = q;
    // Pins pass two flip-flops; edges use the second and third.
    d.sclk = {q.sclk[1:0], i_sclk};
    d.ss = {q.ss[0], i_ss_n};
    d.mosi = {q.mosi[0], i_mosi};
    rise = q.sclk[1] && !q.sclk[2];
    fall = !q.sclk[1] && q.sclk[2];
    active = !q.ss[1];
    rx_byte = {q.rx[6:0], q.mosi[1]};
    rx_done = 1'b0;
    pop = 1'b0;
    d.cal_stb = 1'b0;
    if (q.tmr != WIN) begin
      d.tmr = q.tmr + 1'b1;
    end
    // Receive: sample on rising edge, MSB first.
    if (!active) begin
      d.bitcnt = '0;
    end else if (rise) begin
      d.rx = rx_byte;
      d.bitcnt = q.bitcnt + 1'b1;
      if (q.bitcnt == `TKQ_BIT_LAST) begin
        d.bitcnt = '0;
        rx_done = 1'b1;
      end
    end
    // Send: a new byte starts on the first falling edge of a byte.
    if (active && fall) begin
      if (q.bitcnt == '0) begin
        pop = out_vld;
        d.tx = out_vld ? out_data : `TKQ_CMD_NULL;
      end
      d.miso = d.tx[7];
      d.tx = {d.tx[6:0], 1'b0};
    end
    // Engine: one byte into the FIFO per accepted cycle.
    push = (q.mode == TKQ_EMIT);
    in_data = (q.idx == q.len) ? q.crc : rsp;
    last = q.use_crc ? (q.idx == q.len) : (q.idx == q.len - 1'b1);
    if (push && in_rdy) begin
      d.crc = crc8(q.crc, in_data);
      d.idx = q.idx + 1'b1;
      if (last) begin
        d.mode = TKQ_IDLE;
        d.halt = 1'b0;
        d.idx = '0;
      end
    end
    // Decoder: bytes that arrive while answering are ignored.
    if (rx_done && q.mode == TKQ_IDLE &&
        rx_byte != `TKQ_CMD_NULL) begin
      d.last_cmd = rx_byte;
      d.cal_prev = rx_byte;
      d.tmr = '0;
      d.cmd = rx_byte;
      d.idx = '0;
      d.crc = crc8(`TKQ_CRC_INIT, rx_byte);
      d.use_crc = 1'b1;
      d.len = `TKQ_LEN_ONE;
      unique case (rx_byte)
        `TKQ_CMD_SETUPS, `TKQ_CMD_CALALL, `TKQ_CMD_RESET,
        `TKQ_CMD_GSTAT: begin
          // Served by other logic; nothing to send here.
        end
        `TKQ_CMD_FIRST, `TKQ_CMD_SELF: d.mode = TKQ_EMIT;
        `TKQ_CMD_ALL, `TKQ_CMD_ERR: begin
          d.len = `TKQ_LEN_THREE;
          d.mode = TKQ_EMIT;
        end
        `TKQ_CMD_DUMP: begin
          d.len = `TKQ_LEN_DUMP;
          d.halt = 1'b1;
          d.mode = TKQ_EMIT;
        end
        `TKQ_CMD_NVCRC: begin
          d.use_crc = 1'b0;
          d.mode = TKQ_EMIT;
        end
        `TKQ_CMD_ECHO: begin
          d.ans = ~q.last_cmd;
          d.use_crc = 1'b0;
          d.comm_err = 1'b0;
          d.mode = TKQ_EMIT;
        end
        default: begin
          if (rx_byte[5] || rx_byte[4:0] > `TKQ_KEY_MAX ||
              rx_byte[7:6] == 2'h0) begin
            d.comm_err = 1'b1;
          end else if (rx_byte[7:6] == `TKQ_GRP_DIAG) begin
            d.len = `TKQ_LEN_DIAG;
            d.use_crc = 1'b0;
            d.mode = TKQ_EMIT;
          end else if (rx_byte[7:6] == `TKQ_GRP_KSTAT) begin
            d.mode = TKQ_EMIT;
          end else if (q.cal_prev == rx_byte && q.tmr < WIN) begin
            // Second of a timely pair: schedule and acknowledge.
            d.cal_pend = 1'b1;
            d.cal_key = rx_byte[4:0];
            d.cal_prev = `TKQ_CMD_NULL;
            d.ans = ~rx_byte;
            d.use_crc = 1'b0;
            d.mode = TKQ_EMIT;
          end
        end
      endcase
    end
    // Calibration fires only in the key's own scan slot. A pair for
    // another key decoded in this very cycle wins: it stays pending.
    if (q.cal_pend && i_slot_key == q.cal_key &&
        d.cal_key == q.cal_key) begin
      d.cal_stb = 1'b1;
      d.cal_pend = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{sclk: 3'h7, ss: 2'h3, tmr: WIN, mode: TKQ_IDLE,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state.
  assign o_miso = q.miso;
  assign o_setup_addr = q.idx;
  assign o_diag_key = q.cmd[4:0];
  assign o_cal_stb = q.cal_stb;
  assign o_cal_key = q.cal_key;
  assign o_scan_halt = q.halt;
  assign o_comm_err = q.comm_err;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  // A decoded command of the given code.
  sequence s_cmd(logic [7:0] c);
    rx_done && q.mode == TKQ_IDLE && rx_byte == c;
  endsequence

  multi_touch_a: assert property (
    push && q.cmd == `TKQ_CMD_FIRST && q.idx == '0 |->
      in_data[7] == ($countones(i_keys.detect) >= 2))
    else $error("first-key bit 7 wrong");
  fault_flag_a: assert property (
    push && q.cmd == `TKQ_CMD_FIRST && q.idx == '0 && i_sync_fail |->
      in_data[6]) else $error("first-key bit 6 missing");
  first_key_a: assert property (
    push && q.cmd == `TKQ_CMD_FIRST && q.idx == '0 |->
      !in_data[5] && (in_data[4:0] == `TKQ_NO_TOUCH) == !(|i_keys.detect))
    else $error("first-key index wrong");
  first_crc_a: assert property (
    s_cmd(`TKQ_CMD_FIRST) |=> q.len == `TKQ_LEN_ONE && q.use_crc
      && q.crc == crc8(`TKQ_CRC_INIT, `TKQ_CMD_FIRST))
    else $error("first-key answer setup wrong");
  all_keys_a: assert property (
    s_cmd(`TKQ_CMD_ALL) |=> q.mode == TKQ_EMIT && q.len == `TKQ_LEN_THREE)
    else $error("all-keys length wrong");
  dump_halt_a: assert property (
    s_cmd(`TKQ_CMD_DUMP) |=> o_scan_halt && q.len == `TKQ_LEN_DUMP
      ##1 (o_scan_halt throughout q.mode == TKQ_EMIT [*8]))
    else $error("dump does not halt scanning");
  echo_clear_a: assert property (
    s_cmd(`TKQ_CMD_ECHO) |=> !o_comm_err && q.ans == ~$past(q.last_cmd))
    else $error("echo answer or clear wrong");
  diag_len_a: assert property (
    q.mode == TKQ_EMIT && q.cmd[7:6] == `TKQ_GRP_DIAG |->
      q.len == `TKQ_LEN_DIAG && !q.use_crc)
    else $error("diagnostic framing");
  key_status_a: assert property (
    push && q.cmd[7:6] == `TKQ_GRP_KSTAT && q.idx == '0 |->
      in_data[7:5] == 3'h0 && in_data[3] == i_keys.detect[kk])
    else $error("key status byte wrong");
  cal_slot_a: assert property (
    o_cal_stb |-> $past(i_slot_key) == o_cal_key)
    else $error("calibration outside its slot");
  cal_ack_a: assert property (
    $rose(q.cal_pend) |-> push && in_data == ~q.cmd ##[1:20] !push)
    else $error("calibration ack wrong");
  bad_cmd_a: assert property (
    rx_done && q.mode == TKQ_IDLE && rx_byte[7:6] == 2'h0 &&
      rx_byte[3:0] == 4'h2 |=> o_comm_err)
    else $error("unknown command not flagged");
  back_idle_a: assert property (
    push && in_rdy && last |=> q.mode == TKQ_IDLE && !o_scan_halt)
    else $error("engine does not return to idle");
  error_len_a: assert property (
    s_cmd(`TKQ_CMD_ERR) |=> q.len == `TKQ_LEN_THREE && q.use_crc)
    else $error("error flags framing wrong");
  self_test_a: assert property (
    push && q.cmd == `TKQ_CMD_SELF && q.idx == '0 |->
      in_data == i_line_fault_selftest)
    else $error("self-test byte wrong");
  nv_crc_a: assert property (
    push && q.cmd == `TKQ_CMD_NVCRC |-> in_data == i_nv_crc && last)
    else $error("stored checksum answer wrong");
  diag_order_a: assert property (
    push && q.cmd[7:6] == `TKQ_GRP_DIAG && q.idx == '0 |->
      in_data == i_diag.signal[7:0])
    else $error("diagnostic byte order wrong");
  key_lowref_a: assert property (
    push && q.cmd[7:6] == `TKQ_GRP_KSTAT && q.idx == '0 |->
      in_data[2] == i_keys.lowref[kk] && in_data[0] == i_keys.calfail[kk])
    else $error("key status low reference wrong");
endmodule // tkq_core
`default_nettype wire

// ---- tkq_host.sv ----
/*
  Host model: an SPI master in mode 3 with an 800 ns bit time.
  Assumes the bench calls xfer once per byte and waits for it.
*/
`timescale 1ns/1ps
`default_nettype none
module tkq_host (
  output logic o_sclk,
  output logic o_ss_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // **********************************************************
  // Idle link
  // **********************************************************
  // The clock stands high and select is off between frames.
  initial begin
    o_sclk = 1'b1;
    o_ss_n = 1'b1;
    o_mosi = 1'b1;
  end
  // **********************************************************
  // Byte transfer
  // **********************************************************
  // Data is set after each fall and read at each rise, MSB first.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    // Pins change by non-blocking assignment, so an edge that lands on
    // a device clock edge is seen after that edge, never raced.
    o_ss_n <= 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      o_sclk <= 1'b0;
      o_mosi <= tx[i];
      #400;
      o_sclk <= 1'b1;
      rx[i] = i_miso;
      #400;
    end
    o_ss_n <= 1'b1;
    // A released data line must not keep showing the last bit.
    o_mosi <= ~o_mosi;
    // The gap keeps the device's minimum spacing between bytes.
    #1500;
  endtask
endmodule // tkq_host
`default_nettype wire

// ---- tb.sv ----
/*
  Self-checking bench of the query command decoder.
  Assumes the core, its package and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tkq_pkg::*;
  logic i_mclk, i_rstn, sclk, ss_n, mosi, miso;
  tkq_keys_t keys; // Key state from the sensing side.
  logic sync_fail, self_fail, cal_stb, scan_halt, comm_err, halt_mid;
  logic [7:0] line_fault, nv_crc, setup_data;
  logic [6:0] setup_addr;
  tkq_diag_t diag;
  logic [4:0] diag_key, slot_key, cal_key;
  logic [7:0] rsp [0:100]; // Bytes read back.
  logic [7:0] exp_b [0:100]; // Bytes expected.
  int miscompares, comparisons, t;
  // The setups store and the diagnostics follow the addresses.
  assign setup_data = {1'b0, setup_addr} ^ 8'hA5;
  assign diag = {8'h12, 3'h0, diag_key, 8'h34, 3'h0, diag_key,
                 3'h5, diag_key};
  tkq_core #(.CAL_WIN_CYC(200), .FIFO_DEPTH(8)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_sclk(sclk), .i_ss_n(ss_n),
    .i_mosi(mosi), .o_miso(miso), .i_keys(keys),
    .i_sync_fail(sync_fail), .i_selftest_fail(self_fail),
    .i_line_fault_selftest(line_fault), .i_nv_crc(nv_crc),
    .i_setup_data(setup_data), .o_setup_addr(setup_addr),
    .i_diag(diag), .o_diag_key(diag_key), .i_slot_key(slot_key),
    .o_cal_stb(cal_stb), .o_cal_key(cal_key),
    .o_scan_halt(scan_halt), .o_comm_err(comm_err));
  tkq_host host (.o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi),
                 .i_miso(miso));
  // The clock runs at 10 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // **********************************************************
  // Helpers
  // **********************************************************
  // One CRC-8 step, polynomial 0x31, MSB first.
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ 8'h31) : (x << 1);
    return x;
  endfunction
  // Compares one byte.
  task automatic chk8(input logic [7:0] e, input logic [7:0] a);
    comparisons++;
    if (a !== e) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  // Compares one flag.
  task automatic chkb(input logic e, input logic a);
    comparisons++;
    if (a !== e) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Sends a command, reads n answer bytes, adds the CRC if asked.
  task automatic run(input logic [7:0] c, input int n, input bit use_crc);
    logic [7:0] r, crc;
    host.xfer(c, r);
    crc = crc8(8'h00, c);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, rsp[i]);
      if (i == 1) halt_mid = scan_halt;
    end
    for (int i = 0; i < n - 1; i++) crc = crc8(crc, exp_b[i]);
    if (use_crc) exp_b[n-1] = crc;
    for (int i = 0; i < n; i++) chk8(exp_b[i], rsp[i]);
  endtask
  // **********************************************************
  // Main sequence
  // **********************************************************
  initial begin
    i_rstn = 1'b0;
    keys = '0;
    sync_fail = 1'b0;
    self_fail = 1'b0;
    line_fault = 8'h00;
    nv_crc = 8'h00;
    slot_key = 5'h00;
    halt_mid = 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chkb(1'b0, comm_err);
    keys.detect <= 24'h000208;
    keys.err <= 24'hA50081;
    line_fault <= 8'h96;
    nv_crc <= 8'h3C;
    @(posedge i_mclk);
    exp_b[0] = 8'h83;
    run(8'h06, 2, 1);
    {exp_b[0], exp_b[1], exp_b[2]} = 24'h080200;
    run(8'h07, 4, 1);
    {exp_b[0], exp_b[1], exp_b[2]} = 24'h8100A5;
    run(8'h0B, 4, 1);
    exp_b[0] = 8'h96;
    run(8'h0C, 2, 1);
    exp_b[0] = 8'h3C;
    run(8'h0E, 1, 0);
    {exp_b[0], exp_b[1], exp_b[2], exp_b[3], exp_b[4]} = 40'h05120534A5;
    run(8'h45, 5, 0);
    @(posedge i_mclk);
    keys <= '{detect: 24'h000288, enabled: 24'h80, cal: 24'h80,
              calfail: 24'h80, lowref: 24'h80, err: 24'hA50081};
    @(posedge i_mclk);
    exp_b[0] = 8'h1F;
    run(8'h87, 2, 1);
    exp_b[0] = 8'hC3;
    run(8'h06, 2, 1);
    // An unknown code raises the error; echo shows and clears it.
    run(8'h05, 0, 0);
    chkb(1'b0, comm_err);
    run(8'h02, 0, 0);
    chkb(1'b1, comm_err);
    exp_b[0] = 8'hFD;
    run(8'h0F, 1, 0);
    chkb(1'b0, comm_err);
    // A calibrate pair schedules key 4 and waits for its slot.
    run(8'hC4, 0, 0);
    exp_b[0] = 8'h3B;
    run(8'hC4, 1, 0);
    chk8(8'h04, {3'h0, cal_key});
    chkb(1'b0, cal_stb);
    @(posedge i_mclk);
    slot_key <= 5'h04;
    for (t = 0; t < 20 && cal_stb !== 1'b1; t++) @(negedge i_mclk);
    chkb(1'b1, cal_stb);
    if (cal_stb !== 1'b1) wrap_up;
    // The dump outruns the host, so the FIFO fills and stalls it.
    for (int i = 0; i < 100; i++) exp_b[i] = i[7:0] ^ 8'hA5;
    run(8'h0D, 101, 1);
    chkb(1'b1, halt_mid);
    chkb(1'b0, scan_halt);
    @(posedge i_mclk);
    keys <= '0;
    self_fail <= 1'b1;
    @(posedge i_mclk);
    exp_b[0] = 8'h5F;
    run(8'h06, 2, 1);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
